// ---- verilog/switch_clock_pkg.sv ----
/*
  constants for the switching clock generator: clock rate, frequency table,
  spread and synchronisation figures.
  assumes a 25 mhz system clock feeding every register of the block.
*/
`default_nettype none

package switch_clock_pkg;

  // system clock
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 40;

  // phase accumulator
  localparam int unsigned ACC_W           = 24;
  localparam logic [3:0]  CFG_RESET       = 4'h0;
  localparam logic [3:0]  CODE_HIGH_FIRST = 4'h7;
  localparam logic [3:0]  CODE_OPEN       = 4'hd;

  // spread spectrum: 8.3 khz triangle, +-7.5 %
  localparam int unsigned SS_MOD_HZ       = 8300;
  localparam int unsigned SS_RANGE_PERMIL = 75;
  localparam int          SS_HALF         = CLK_HZ / (2 * SS_MOD_HZ);

  // synchronisation loss: two periods of the slowest capture frequency
  localparam int unsigned SYNC_MIN_HZ     = 320_000;
  localparam int unsigned SYNC_LOSS_CYC   = (2 * CLK_HZ) / SYNC_MIN_HZ;
  localparam logic [7:0]  SYNC_LOSS       = 8'(SYNC_LOSS_CYC);

  // nominal frequency for each resistor code, ascending resistor order
  function automatic int unsigned select_pin_a_hz(input logic [3:0] code);
    case (code)
      4'h0:    select_pin_a_hz = 440_000;
      4'h1:    select_pin_a_hz = 320_000;
      4'h2:    select_pin_a_hz = 360_000;
      4'h3:    select_pin_a_hz = 400_000;
      4'h4:    select_pin_a_hz = 480_000;
      4'h5:    select_pin_a_hz = 520_000;
      4'h6:    select_pin_a_hz = 560_000;
      4'h7:    select_pin_a_hz = 1_600_000;
      4'h8:    select_pin_a_hz = 1_800_000;
      4'h9:    select_pin_a_hz = 2_000_000;
      4'ha:    select_pin_a_hz = 2_400_000;
      4'hb:    select_pin_a_hz = 2_600_000;
      4'hc:    select_pin_a_hz = 2_800_000;
      default: select_pin_a_hz = 2_200_000;
    endcase
  endfunction : select_pin_a_hz

  // accumulator step per clock for a code
  function automatic logic [ACC_W-1:0] select_pin_a_inc(input logic [3:0] code);
    longint unsigned num;
    num      = (longint'(select_pin_a_hz(code)) << ACC_W) + longint'(CLK_HZ / 2);
    select_pin_a_inc = ACC_W'(num / longint'(CLK_HZ));
  endfunction : select_pin_a_inc

endpackage : switch_clock_pkg

`default_nettype wire

// ---- verilog/switching_clock_generator.sv ----
/*
  switching clock generator: strap-latched frequency choice, phase accumulator,
  falling-edge synchronisation and triangular spread spectrum.
  assumes pins i_select_code, i_sync and i_spread_enable_pin are asynchronous;
  i_startup_done, i_pwm_mode and i_duty come from logic on i_clock.
*/
// Contract
// - in pwm mode, turn high and low side on and off once per period
// - latch the frequency selection only during startup, ignore later changes
// - low range 320..560 khz; grounded or lowest code gives 440 khz
// - high range 1.6..2.8 mhz; open or above highest code gives 2.2 mhz
// - in pwm mode lock switching frequency to the external sync clock
// - when synchronised, each period starts on a sync falling edge
// - sync duty cycle sets phase; 50 percent gives about zero phase (the code starts each period on the sync falling edge whatever the duty)
// - synchronisation active only after startup and sync accepted
// - spread spectrum only in pwm mode with no external clock present
// - triangular sweep at about 8.3 khz spanning about +-7.5 percent
// - spread enable pin high enables modulation, low disables it
`timescale 1ns/1ns
`default_nettype none

module switching_clock_generator
  import switch_clock_pkg::*;
#(
  parameter int unsigned SYNC_ACCEPT_EDGES = 4
) (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  // configuration pins
  input  wire logic [3:0] i_select_code,
  input  wire logic       i_spread_enable_pin,
  // external synchronisation clock
  input  wire logic       i_sync,
  // regulation loop
  input  wire logic       i_startup_done,
  input  wire logic       i_pwm_mode,
  input  wire logic [7:0] i_duty,
  // power stage and status
  output logic            o_high_side_on,
  output logic            o_low_side_on,
  output logic            o_period_start,
  output logic            o_sync_active,
  output logic            o_spread_active,
  output logic [3:0]      o_select_pin_a_code,
  output logic            o_high_range
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [3:0]       sel_meta;
    logic [3:0]       sel_s;
    logic             sync_meta;
    logic             sync_s;
    logic             sync_prev;
    logic             ss_meta;
    logic             ss_s;
    logic [3:0]       cfg;
    logic [ACC_W-1:0] acc;
    logic [11:0]      tri_pos;
    logic             tri_down;
    logic [3:0]       edges;
    logic [7:0]       gap;
    logic             seen;
    logic             locked;
    logic             spread;
    logic             pulse;
    logic             hs;
    logic             ls;
    logic             high;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic             fall;
  logic [ACC_W-1:0] inc_nom;
  logic [ACC_W-1:0] inc;
  logic [ACC_W-1:0] span;
  logic [ACC_W:0]   sum;
  int               dev;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    dev = 0;
    // two-stage synchronisers; first stage is read only by the second
    s_d.sel_meta  = i_select_code;
    s_d.sel_s     = s_q.sel_meta;
    s_d.sync_meta = i_sync;
    s_d.sync_s    = s_q.sync_meta;
    s_d.sync_prev = s_q.sync_s;
    s_d.ss_meta   = i_spread_enable_pin;
    s_d.ss_s      = s_q.ss_meta;
    fall          = s_q.sync_prev & ~s_q.sync_s;

    // strap follows the pin until startup completes, then stays frozen
    if (!i_startup_done) begin
      s_d.cfg = s_q.sel_s;
    end
    inc_nom = select_pin_a_inc(s_q.cfg);
    // range flag registered with the code so both outputs move on one edge
    s_d.high = (s_d.cfg >= CODE_HIGH_FIRST);

    // triangle position walks 0..SS_HALF and back, one step per clock
    if (s_q.tri_down) begin
      if (s_q.tri_pos == 12'h000) begin
        s_d.tri_down = 1'b0;
      end else begin
        s_d.tri_pos = s_q.tri_pos - 12'h001;
      end
    end else begin
      if (s_q.tri_pos >= 12'(SS_HALF)) begin
        s_d.tri_down = 1'b1;
      end else begin
        s_d.tri_pos = s_q.tri_pos + 12'h001;
      end
    end
    span = ACC_W'((32'(inc_nom) * SS_RANGE_PERMIL) / 32'd1000);
    dev  = (int'(span) * (2 * int'(s_q.tri_pos) - SS_HALF)) / SS_HALF;

    // any recent falling edge means an external clock is present
    s_d.spread = i_pwm_mode & s_q.ss_s & ~s_q.seen;
    inc = s_q.spread ? ACC_W'(int'(inc_nom) + dev) : inc_nom;
    sum = {1'b0, s_q.acc} + {1'b0, inc};

    // sync supervision: edges counted until accepted, lost on a long gap
    if (fall) begin
      s_d.gap  = 8'h00;
      s_d.seen = 1'b1;
      if (!s_q.locked && s_q.edges < 4'(SYNC_ACCEPT_EDGES)) begin
        s_d.edges = s_q.edges + 4'h1;
      end
    end else if (s_q.gap < SYNC_LOSS) begin
      s_d.gap = s_q.gap + 8'h01;
    end else begin
      s_d.seen  = 1'b0;
      s_d.edges = 4'h0;
    end
    if (!i_pwm_mode || !i_startup_done || !s_d.seen) begin
      s_d.locked = 1'b0;
    end else if (s_d.edges >= 4'(SYNC_ACCEPT_EDGES)) begin
      s_d.locked = 1'b1;
    end

    // period start: sync falling edge when locked, else accumulator wrap
    s_d.pulse = 1'b0;
    if (s_q.locked) begin
      if (fall) begin
        s_d.acc   = '0;
        s_d.pulse = 1'b1;
      end else if (!sum[ACC_W]) begin
        s_d.acc = sum[ACC_W-1:0];
      end
      // a late edge holds the ramp at its top; relies on internal >= sync
      // frequency
    end else begin
      s_d.acc   = sum[ACC_W-1:0];
      s_d.pulse = sum[ACC_W];
    end

    // one on/off pair per period; the duty figure comes from the loop
    s_d.hs = i_pwm_mode & (s_d.acc[ACC_W-1 -: 8] < i_duty);
    s_d.ls = i_pwm_mode & ~s_d.hs;
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      s_q     <= '0;
      s_q.cfg <= CFG_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign o_high_side_on  = s_q.hs;
  assign o_low_side_on   = s_q.ls;
  assign o_period_start  = s_q.pulse;
  assign o_sync_active   = s_q.locked;
  assign o_spread_active = s_q.spread;
  assign o_select_pin_a_code     = s_q.cfg;
  assign o_high_range    = s_q.high;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  a_cfg_frozen: assert property ($past(i_startup_done) |-> s_q.cfg == $past(s_q.cfg))
    else $error("frequency code changed after startup");

  a_low_default: assert property (!i_startup_done && s_q.sel_s == 4'h0 |=> select_pin_a_hz(s_q.cfg) == 440_000)
    else $error("grounded selection did not give 440 khz");

  a_high_default: assert property (
    !i_startup_done && s_q.sel_s >= CODE_OPEN |=> select_pin_a_hz(s_q.cfg) == 2_200_000)
    else $error("open selection did not give 2.2 mhz");

  a_sync_start: assert property (
    s_q.locked && s_q.sync_prev && !s_q.sync_s |=> o_period_start && s_q.acc == '0)
    else $error("locked falling edge did not start a period");

  a_sync_gate: assert property (o_sync_active |-> $past(i_startup_done) && $past(i_pwm_mode))
    else $error("sync active outside startup-complete pwm mode");

  a_spread_gate: assert property (o_spread_active |-> !$past(s_q.seen) && $past(i_pwm_mode))
    else $error("spread active with external clock or outside pwm");

  a_spread_pin: assert property (!s_q.ss_s |=> !o_spread_active)
    else $error("spread active with enable pin low");

  a_tri_bound: assert property (s_q.tri_pos <= 12'(SS_HALF) ##1 s_q.tri_pos <= 12'(SS_HALF))
    else $error("triangle left its sweep range");

  a_stage_excl: assert property (!(o_high_side_on && o_low_side_on))
    else $error("power stages overlap");

  a_stage_idle: assert property (!i_pwm_mode |=> !o_high_side_on && !o_low_side_on)
    else $error("power stages switch outside pwm");

  a_pulse_gap: assert property (!s_q.locked && o_period_start |=> !o_period_start)
    else $error("two free-running periods back to back");

endmodule : switching_clock_generator

`default_nettype wire

// ---- verification/sync_source.sv ----
/*
  partner: external synchronisation clock source.
  assumes the bench raises i_run only with a period and duty that suit the latched range.
*/
`timescale 1ns/1ns
`default_nettype none

module sync_source #(
  parameter int unsigned PERIOD_NS = 2800,
  parameter int unsigned DUTY_PCT  = 50
) (
  // control
  input  wire logic i_run,
  // clock to the block
  output var  logic o_sync
);
  // idles high between frames so no stray falling edge reaches the block
  initial begin
    o_sync = 1'b1;
    #13;
    forever begin
      if (i_run) begin
        o_sync = 1'b1;
        #(PERIOD_NS * DUTY_PCT / 100);
        o_sync = 1'b0;
        #(PERIOD_NS - PERIOD_NS * DUTY_PCT / 100);
      end else begin
        o_sync = 1'b1;
        #20;
      end
    end
  end
endmodule : sync_source

`default_nettype wire

// ---- verification/tb_switching_clock_generator.sv ----
/*
  bench for the switching clock generator: code latch, free run, spread, sync.
  assumes the sync source partner at 2800 ns, above the 440 khz period.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_switching_clock_generator;
  import switch_clock_pkg::*;
  logic       clk  = 1'b0;
  logic       rst  = 1'b1;
  logic       ssen = 1'b0;
  logic       run  = 1'b0;
  logic       up   = 1'b0;
  logic       pwm  = 1'b0;
  logic [3:0] code = 4'h0;
  logic       hs, ls, ps, sa, spa, hr, syn;
  logic [3:0] fc;
  logic [7:0] g, mn, mx;
  int         error_cnt    = 0;
  int         total_checks = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  sync_source src (.i_run(run), .o_sync(syn));
  switching_clock_generator uut (.i_clock(clk), .i_reset(rst), .i_select_code(code), .i_spread_enable_pin(ssen),
    .i_sync(syn), .i_startup_done(up), .i_pwm_mode(pwm), .i_duty(8'h80), .o_high_side_on(hs),
    .o_low_side_on(ls), .o_period_start(ps), .o_sync_active(sa), .o_spread_active(spa),
    .o_select_pin_a_code(fc), .o_high_range(hr));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // cycles up to the next period start; a missing pulse ends the run
  task automatic wait_pulse(output logic [7:0] n);
    n = 8'h00;
    for (int i = 1; i <= 200 && n == 8'h00; i++) begin
      tick(1);
      if (ps === 1'b1) n = 8'(i);
    end
    if (n == 8'h00) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, 8'hc8);
      wrap_up();
    end
  endtask : wait_pulse

  task automatic do_reset();
    rst = 1'b1;
    up = 1'b0;
    pwm = 1'b0;
    run = 1'b0;
    ssen = 1'b0;
    code = 4'h0;
    tick(2);
    rst = 1'b0;
  endtask : do_reset

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_codes();
    for (int c = 0; c < 16; c++) begin
      code = 4'(c);
      tick(4);
      check(8'(fc), 8'(c));
      check(8'(hr), 8'(c >= 7));
    end
    up = 1'b1;
    code = 4'h3;
    tick(6);
    check(8'(fc), 8'h0f);
  endtask : t_codes

  task automatic t_free();
    up = 1'b1;
    pwm = 1'b1;
    wait_pulse(g);
    check(8'(hs), 8'h01);
    wait_pulse(g);
    check(8'(g >= 8'd56 && g <= 8'd57), 8'h01);
    tick(40);
    check(8'(ls && !hs), 8'h01);
    pwm = 1'b0;
    tick(3);
    check(8'(hs || ls), 8'h00);
  endtask : t_free

  task automatic t_spread();
    pwm = 1'b1;
    ssen = 1'b1;
    tick(8);
    check(8'(spa), 8'h01);
    mn = 8'hff;
    mx = 8'h00;
    wait_pulse(g);
    // 120 periods cover two triangle sweeps
    repeat (120) begin
      wait_pulse(g);
      if (g < mn) mn = g;
      if (g > mx) mx = g;
    end
    check(8'(mn >= 8'd52 && mn <= 8'd54 && mx >= 8'd59 && mx <= 8'd62), 8'h01);
    pwm = 1'b0;
    tick(8);
    check(8'(spa), 8'h00);
    pwm = 1'b1;
    ssen = 1'b0;
    tick(8);
    check(8'(spa), 8'h00);
  endtask : t_spread

  task automatic t_sync();
    pwm = 1'b1;
    ssen = 1'b1;
    run = 1'b1;
    tick(700);
    check(8'(sa), 8'h00);
    up = 1'b1;
    for (int i = 0; i < 800 && sa !== 1'b1; i++) tick(1);
    check(8'(sa), 8'h01);
    if (sa !== 1'b1) wrap_up();
    check(8'(spa), 8'h00);
    g = 8'h00;
    for (int i = 0; i < 100 && g[1:0] != 2'b10; i++) begin
      tick(1);
      g = {g[6:0], syn};
    end
    check(8'(g[1:0]), 8'h02);
    // fall seen on the edge that loads the first stage; two more edges through the synchroniser and register
    wait_pulse(g);
    check(g, 8'd2);
    wait_pulse(g);
    check(g, 8'd70);
    run = 1'b0;
    tick(200);
    check(8'(sa), 8'h00);
    check(8'(spa), 8'h01);
  endtask : t_sync

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    do_reset();
    check({fc, hs, ls, ps, sa}, 8'h00);
    check({6'h00, hr, spa}, 8'h00);
    t_codes();
    do_reset();
    t_free();
    t_spread();
    do_reset();
    t_sync();
    wrap_up();
  end
endmodule : tb_switching_clock_generator

`default_nettype wire
